// file: verilog/ext_irq_pkg.sv
package ext_irq_pkg;
   typedef logic [7:0] sfr_byte_t;
   // Register addresses on the special function bus
   localparam sfr_byte_t ENABLE_TWO_ADDR = 8'he7;
   localparam sfr_byte_t PRIORITY_TWO_ADDR = 8'hf7;
   localparam sfr_byte_t EXT_CONFIG_ADDR = 8'he4;
   localparam sfr_byte_t TIMER_CONTROL_ADDR = 8'h88;
   // Pages that reach the paged registers
   localparam sfr_byte_t PAGE_ZERO = 8'h00;
   localparam sfr_byte_t PAGE_CONFIG = 8'h0f;
   // Reset values
   localparam logic [2:0] ENABLE_TWO_RESET = 3'h0;
   localparam logic [2:0] PRIORITY_TWO_RESET = 3'h0;
   localparam sfr_byte_t EXT_CONFIG_RESET = 8'h00;
   localparam logic [1:0] EDGE_SELECT_RESET = 2'h0;
   localparam logic [1:0] PENDING_RESET = 2'h0;
   // Bit positions in the enable and priority registers
   localparam int PORT_MATCH_BIT = 2;
   localparam int CAN_CTRL_BIT = 1;
   localparam int DROPOUT_BIT = 0;
   localparam int IMPLEMENTED_BITS = 3;
   // Config register fields, one nibble per external input
   localparam int PIN_SELECT_LSB = 0;
   localparam int PIN_SELECT_WIDTH = 3;
   localparam int POLARITY_BIT = 3;
   localparam int CONFIG_STRIDE = 4;
   // Timer control fields, one bit pair per external input
   localparam int EDGE_SELECT_BIT = 0;
   localparam int PENDING_BIT = 1;
   localparam int TIMER_STRIDE = 2;
   localparam int EXT_COUNT = 2;
   localparam int PORT_PINS = 8;
endpackage

// file: verilog/ext_irq_and_enable_prio2.sv
// Overview of operation
// - Upper five bits read zero, writes ignored
// - Enable bit 2 gates port match request
// - Enable bit 1 gates CAN controller requests
// - Enable bit 0 gates regulator dropout request
// - Priority bit 2 sets port match level
// - Priority bit 1 sets CAN controller level
// - Priority bit 0 sets dropout level
// - Enable register at 0xE7, every page
// - Priority register at 0xF7, pages 0x00/0x0F
// - Polarity bit: 0 active low, 1 high
// - Timer control bit: 1 edge, 0 level
// - Pin watched without disturbing crossbar peripheral
// - Pending flags are timer control bits 1,3
// - Edge pending cleared when CPU vectors
// - Level pending mirrors input active state
// - Three-bit select picks port 1 pin
// - Polarity at config bits 7 and 3
module ext_irq_and_enable_prio2
#(
   parameter int PIN_COUNT = 8
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire ext_irq_pkg::sfr_byte_t sfr_addr,
   input wire ext_irq_pkg::sfr_byte_t sfr_page,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire ext_irq_pkg::sfr_byte_t sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic [PIN_COUNT-1:0] port1_in,
   input wire logic port_match_src,
   input wire logic can_ctrl_src,
   input wire logic regulator_dropout_src,
   input wire logic [1:0] ext_vector_ack,
   output logic port_match_irq_req,
   output logic can_ctrl_irq_req,
   output logic regulator_dropout_irq_req,
   output logic port_match_irq_high,
   output logic can_ctrl_irq_high,
   output logic regulator_dropout_irq_high,
   output logic [1:0] ext_irq_req
);
   import ext_irq_pkg::*;

   // Refuse a port width the pin select cannot cover
   if (PIN_COUNT != PORT_PINS)
   begin : g_bad_width
      $error("PIN_COUNT must equal the port width");
   end

   logic [IMPLEMENTED_BITS-1:0] enable_two_reg;
   logic [IMPLEMENTED_BITS-1:0] priority_two_reg;
   sfr_byte_t config_reg;
   logic [1:0] edge_sel_reg;
   logic [1:0] pending_reg;
   logic [PIN_COUNT-1:0] pin_meta_reg;
   logic [PIN_COUNT-1:0] pin_sync_reg;
   logic [1:0] active_prev_reg;
   sfr_byte_t rdata_reg;
   logic [2:0] src_req_reg;
   logic [1:0] active;
   logic [1:0] rise;
   logic [1:0] raw_active;
   logic priority_page_ok;
   logic wr_enable;
   logic wr_priority;
   logic wr_config;
   logic wr_timer;
   sfr_byte_t rdata_next;

   // Write decode with page qualification
   assign priority_page_ok = (sfr_page == PAGE_ZERO) || (sfr_page == PAGE_CONFIG);
   assign wr_enable = sfr_wr && (sfr_addr == ENABLE_TWO_ADDR);
   assign wr_priority = sfr_wr && (sfr_addr == PRIORITY_TWO_ADDR) && priority_page_ok;
   assign wr_config = sfr_wr && (sfr_addr == EXT_CONFIG_ADDR) && (sfr_page == PAGE_CONFIG);
   assign wr_timer = sfr_wr && (sfr_addr == TIMER_CONTROL_ADDR);

   // Enable register, only the low three bits are stored
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         enable_two_reg <= ENABLE_TWO_RESET;
      else if (wr_enable)
         enable_two_reg <= sfr_wdata[IMPLEMENTED_BITS-1:0];
   end

   // Priority register
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         priority_two_reg <= PRIORITY_TWO_RESET;
      else if (wr_priority)
         priority_two_reg <= sfr_wdata[IMPLEMENTED_BITS-1:0];
   end

   // External input config: polarity and pin select
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         config_reg <= EXT_CONFIG_RESET;
      else if (wr_config)
         config_reg <= sfr_wdata;
   end

   // Sensing type bits of the timer control register
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         edge_sel_reg <= EDGE_SELECT_RESET;
      else if (wr_timer)
      begin
         edge_sel_reg[0] <= sfr_wdata[EDGE_SELECT_BIT];
         edge_sel_reg[1] <= sfr_wdata[EDGE_SELECT_BIT+TIMER_STRIDE];
      end
   end

   // Port pins only sampled, never driven
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         // Idle level of the pins, so no false activation follows reset
         pin_meta_reg <= '1;
         pin_sync_reg <= '1;
      end
      else
      begin
         pin_meta_reg <= port1_in;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // Per input: pick pin, apply polarity, track pending flag
   for (genvar i = 0; i < EXT_COUNT; i++)
   begin : g_ext
      logic [PIN_SELECT_WIDTH-1:0] sel;
      logic pol;
      assign sel = config_reg[PIN_SELECT_LSB+i*CONFIG_STRIDE +: PIN_SELECT_WIDTH];
      assign pol = config_reg[POLARITY_BIT+i*CONFIG_STRIDE];
      assign active[i] = ~(pin_sync_reg[sel] ^ pol);
      assign raw_active[i] = ~(port1_in[sel] ^ pol);
      assign rise[i] = active[i] & ~active_prev_reg[i];

      always_ff @(posedge clk or negedge reset_n)
      begin
         if (!reset_n)
            active_prev_reg[i] <= 1'b0;
         else
            active_prev_reg[i] <= active[i];
      end

      // Activation beats any clear in the same cycle
      always_ff @(posedge clk or negedge reset_n)
      begin
         if (!reset_n)
            pending_reg[i] <= PENDING_RESET[i];
         else if (!edge_sel_reg[i])
            pending_reg[i] <= active[i];
         else if (rise[i])
            pending_reg[i] <= 1'b1;
         else if (wr_timer)
            pending_reg[i] <= sfr_wdata[PENDING_BIT+i*TIMER_STRIDE];
         else if (ext_vector_ack[i])
            pending_reg[i] <= 1'b0;
      end
   end

   // Masked requests toward the CPU
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         src_req_reg <= 3'h0;
      else
      begin
         src_req_reg[PORT_MATCH_BIT] <= port_match_src & enable_two_reg[PORT_MATCH_BIT];
         src_req_reg[CAN_CTRL_BIT] <= can_ctrl_src & enable_two_reg[CAN_CTRL_BIT];
         src_req_reg[DROPOUT_BIT] <= regulator_dropout_src & enable_two_reg[DROPOUT_BIT];
      end
   end

   // Read mux, unmapped addresses read zero
   always_comb
   begin
      rdata_next = 8'h00;
      if (sfr_addr == ENABLE_TWO_ADDR)
         rdata_next[IMPLEMENTED_BITS-1:0] = enable_two_reg;
      else if ((sfr_addr == PRIORITY_TWO_ADDR) && priority_page_ok)
         rdata_next[IMPLEMENTED_BITS-1:0] = priority_two_reg;
      else if ((sfr_addr == EXT_CONFIG_ADDR) && (sfr_page == PAGE_CONFIG))
         rdata_next = config_reg;
      else if (sfr_addr == TIMER_CONTROL_ADDR)
      begin
         rdata_next[EDGE_SELECT_BIT] = edge_sel_reg[0];
         rdata_next[PENDING_BIT] = pending_reg[0];
         rdata_next[EDGE_SELECT_BIT+TIMER_STRIDE] = edge_sel_reg[1];
         rdata_next[PENDING_BIT+TIMER_STRIDE] = pending_reg[1];
      end
   end

   // Read data registered, held between reads
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         rdata_reg <= 8'h00;
      else if (sfr_rd)
         rdata_reg <= rdata_next;
   end

   // Outputs straight from flip-flops
   assign sfr_rdata = rdata_reg;
   assign port_match_irq_req = src_req_reg[PORT_MATCH_BIT];
   assign can_ctrl_irq_req = src_req_reg[CAN_CTRL_BIT];
   assign regulator_dropout_irq_req = src_req_reg[DROPOUT_BIT];
   assign port_match_irq_high = priority_two_reg[PORT_MATCH_BIT];
   assign can_ctrl_irq_high = priority_two_reg[CAN_CTRL_BIT];
   assign regulator_dropout_irq_high = priority_two_reg[DROPOUT_BIT];
   assign ext_irq_req = pending_reg;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   // Unused bits always read back zero
   a_unused_read_zero: assert property (
      sfr_rd && (sfr_addr == ENABLE_TWO_ADDR || sfr_addr == PRIORITY_TWO_ADDR)
      |=> sfr_rdata[7:3] == 5'h00)
      else $error("unused register bits read nonzero");

   // Port match request masked when disabled
   a_match_masked: assert property (
      !enable_two_reg[PORT_MATCH_BIT] |=> !port_match_irq_req)
      else $error("port match request passed while disabled");

   // CAN request follows source when enabled
   a_can_gate: assert property (
      enable_two_reg[CAN_CTRL_BIT] |=> can_ctrl_irq_req == $past(can_ctrl_src))
      else $error("CAN request does not follow enabled source");

   // Dropout request masked when disabled
   a_dropout_masked: assert property (
      !enable_two_reg[DROPOUT_BIT] |=> !regulator_dropout_irq_req)
      else $error("dropout request passed while disabled");

   // Priority write on a legal page sets the level
   a_match_level: assert property (
      sfr_wr && sfr_addr == PRIORITY_TWO_ADDR && sfr_page == PAGE_ZERO
      |=> port_match_irq_high == $past(sfr_wdata[PORT_MATCH_BIT]))
      else $error("port match priority not written");

   a_can_level: assert property (
      sfr_wr && sfr_addr == PRIORITY_TWO_ADDR && sfr_page == PAGE_CONFIG
      |=> can_ctrl_irq_high == $past(sfr_wdata[CAN_CTRL_BIT]))
      else $error("CAN priority not written");

   a_dropout_level: assert property (
      sfr_wr && sfr_addr == PRIORITY_TWO_ADDR && priority_page_ok
      |=> regulator_dropout_irq_high == $past(sfr_wdata[DROPOUT_BIT]))
      else $error("dropout priority not written");

   // Enable register writable on any page
   a_enable_any_page: assert property (
      sfr_wr && sfr_addr == ENABLE_TWO_ADDR
      |=> enable_two_reg == $past(sfr_wdata[2:0]))
      else $error("enable register write lost");

   // Priority register untouched from other pages
   a_priority_paged: assert property (
      sfr_wr && sfr_addr == PRIORITY_TWO_ADDR && !priority_page_ok
      |=> $stable(priority_two_reg))
      else $error("priority register written from wrong page");

   // Level mode flag mirrors the active input
   a_level_mirror: assert property (
      !edge_sel_reg[0] |=> pending_reg[0] == $past(active[0]))
      else $error("level pending does not mirror input");

   // Level mode end to end from the pin, three cycles
   a_pin_path: assert property (
      ($stable(config_reg) && !edge_sel_reg[1])[*3]
      |-> pending_reg[1] == $past(raw_active[1], 3))
      else $error("selected pin not reflected in pending flag");

   // Edge activation sets the flag next cycle
   a_edge_sets: assert property (
      edge_sel_reg[1] && rise[1] |=> pending_reg[1])
      else $error("edge activation missed");

   // Vectoring clears an edge flag
   a_vector_clears: assert property (
      edge_sel_reg[0] && ext_vector_ack[0] && !rise[0] && !wr_timer
      |=> !pending_reg[0])
      else $error("edge pending not cleared on vector");

   // Pending flags readable at bits 1 and 3
   a_pending_read: assert property (
      sfr_rd && sfr_addr == TIMER_CONTROL_ADDR
      |=> sfr_rdata[3] == $past(pending_reg[1]) && sfr_rdata[1] == $past(pending_reg[0]))
      else $error("pending flags misplaced in timer control");

endmodule

// file: testbench/ext_source_model.sv
module ext_source_model
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] pin_cmd,
   output logic [7:0] pins
);
   timeunit 1ns;
   timeprecision 1ps;

   // Sources hold their level until the bench releases it; pins idle high
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         pins <= 8'hff;
      else
         pins <= pin_cmd;
   end
endmodule

// file: testbench/ext_irq_and_enable_prio2_test.sv
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin miscompares++; \
   $display("Error %s expected %h seen %h", nm, ex, got); end end

module ext_irq_and_enable_prio2_test;
   timeunit 1ns;
   timeprecision 1ps;
   import ext_irq_pkg::*;

   typedef struct {sfr_byte_t addr, wpage, wdata, rpage, exp;} reg_row_t;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   sfr_byte_t sfr_addr = 8'h00, sfr_page = 8'h00, sfr_wdata = 8'h00;
   logic sfr_wr = 1'b0, sfr_rd = 1'b0;
   logic [7:0] sfr_rdata, port1_in, pin_cmd = 8'hff, rd_val;
   logic [2:0] src = 3'h0, req, high;
   logic [1:0] ext_vector_ack = 2'h0, ext_irq_req;
   int miscompares = 0, checks = 0;
   reg_row_t rows [8] = '{
      '{8'he7, 8'h00, 8'hff, 8'h05, 8'h07}, '{8'he7, 8'h05, 8'h05, 8'h03, 8'h05},
      '{8'hf7, 8'h00, 8'hff, 8'h0f, 8'h07}, '{8'hf7, 8'h0f, 8'h02, 8'h00, 8'h02},
      '{8'hf7, 8'h03, 8'h05, 8'h00, 8'h02}, '{8'hf7, 8'h00, 8'h00, 8'h03, 8'h00},
      '{8'he4, 8'h0f, 8'ha5, 8'h0f, 8'ha5}, '{8'he4, 8'h00, 8'h11, 8'h0f, 8'ha5}};

   always #20 clk = ~clk;

   ext_source_model ext_source_model_inst (.clk(clk), .reset_n(reset_n), .pin_cmd(pin_cmd),
      .pins(port1_in));

   ext_irq_and_enable_prio2 ext_irq_and_enable_prio2_inst (.clk(clk), .reset_n(reset_n),
      .sfr_addr(sfr_addr), .sfr_page(sfr_page), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .port1_in(port1_in),
      .port_match_src(src[2]), .can_ctrl_src(src[1]), .regulator_dropout_src(src[0]),
      .ext_vector_ack(ext_vector_ack), .port_match_irq_req(req[2]),
      .can_ctrl_irq_req(req[1]), .regulator_dropout_irq_req(req[0]),
      .port_match_irq_high(high[2]), .can_ctrl_irq_high(high[1]),
      .regulator_dropout_irq_high(high[0]), .ext_irq_req(ext_irq_req));

   // Register write, one strobe cycle
   task automatic wr(input sfr_byte_t a, input sfr_byte_t p, input sfr_byte_t d);
      @(posedge clk);
      sfr_addr <= a;
      sfr_page <= p;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge clk);
      sfr_wr <= 1'b0;
   endtask

   // Register read, data taken once the answering edge has landed
   task automatic rd(input sfr_byte_t a, input sfr_byte_t p);
      @(posedge clk);
      sfr_addr <= a;
      sfr_page <= p;
      sfr_rd <= 1'b1;
      @(posedge clk);
      sfr_rd <= 1'b0;
      @(negedge clk);
      rd_val = sfr_rdata;
   endtask

   // Pin change, then the model delay plus the synchronizer
   task automatic pins(input logic [7:0] v);
      @(posedge clk);
      pin_cmd <= v;
      repeat (5) @(posedge clk);
      @(negedge clk);
   endtask

   task automatic finish_test;
      if (miscompares == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      miscompares++;
      finish_test;
   end

   initial
   begin
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      // Reset values
      rd(8'he7, 8'h00);
      `CHK("enable reset", 8'h00, rd_val)
      rd(8'h88, 8'h00);
      `CHK("timer control reset", 8'h00, rd_val)
      // Table of register accesses
      foreach (rows[i])
      begin
         wr(rows[i].addr, rows[i].wpage, rows[i].wdata);
         rd(rows[i].addr, rows[i].rpage);
         `CHK("register row", rows[i].exp, rd_val)
      end
      rd(8'h55, 8'h00);
      `CHK("unmapped read", 8'h00, rd_val)
      // Every enable and priority code
      for (int i = 0; i < 8; i++)
      begin
         wr(8'he7, 8'h00, 8'hf8 | i[7:0]);
         wr(8'hf7, 8'h0f, ~i[7:0]);
         src <= 3'h7;
         repeat (2) @(posedge clk);
         @(negedge clk);
         `CHK("request gate", i[2:0], req)
         `CHK("priority level", ~i[2:0], high)
         src <= 3'h0;
         repeat (2) @(posedge clk);
         @(negedge clk);
         `CHK("request idle", 3'h0, req)
      end
      // Pin selection in level mode, A active high, B active low, same pin
      for (int s = 0; s < 8; s++)
      begin
         wr(8'he4, 8'h0f, 8'h08 | s[7:0] | (s[7:0] << 4));
         pins(8'h01 << s);
         `CHK("selected pin active", 2'h1, ext_irq_req)
         pins(~(8'h01 << s));
         `CHK("selected pin idle", 2'h2, ext_irq_req)
      end
      // Level mode: A high on pin 5, B low on pin 2
      wr(8'he4, 8'h0f, 8'h2d);
      pins(8'hff);
      @(posedge clk);
      ext_vector_ack <= 2'h3;
      @(posedge clk);
      ext_vector_ack <= 2'h0;
      @(negedge clk);
      `CHK("level ignores ack", 2'h1, ext_irq_req)
      pins(8'hdb);
      rd(8'h88, 8'h00);
      `CHK("level B pending bit", 8'h08, rd_val)
      pins(8'hdf);
      `CHK("level both idle", 2'h0, ext_irq_req)
      // Edge mode on both inputs
      wr(8'h88, 8'h00, 8'h05);
      pins(8'hff);
      pins(8'hdf);
      `CHK("edge A latched", 2'h1, ext_irq_req)
      @(posedge clk);
      ext_vector_ack <= 2'h1;
      @(posedge clk);
      ext_vector_ack <= 2'h0;
      @(negedge clk);
      `CHK("edge A cleared", 2'h0, ext_irq_req)
      pins(8'hdb);
      rd(8'h88, 8'h00);
      `CHK("edge B pending bit", 8'h0d, rd_val)
      wr(8'h88, 8'h00, 8'h05);
      @(negedge clk);
      `CHK("edge B written clear", 2'h0, ext_irq_req)
      // Reset in mid-run
      wr(8'he7, 8'h00, 8'h07);
      wr(8'hf7, 8'h00, 8'h07);
      src <= 3'h7;
      repeat (2) @(posedge clk);
      @(negedge clk);
      `CHK("request before reset", 3'h7, req)
      @(posedge clk);
      reset_n <= 1'b0;
      @(negedge clk);
      `CHK("reset request", 3'h0, req)
      `CHK("reset priority", 3'h0, high)
      @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      @(negedge clk);
      `CHK("no pending after reset", 2'h0, ext_irq_req)
      rd(8'he7, 8'h00);
      `CHK("enable after reset", 8'h00, rd_val)
      finish_test;
   end
endmodule
